// ---- rtl/fcdma_pkg.sv ----
// Package for the four-channel DMA controller: register map, fields, reset values.
// Assumes a single 50 MHz clock and the plain strobe register port.
package fcdma_pkg;
    localparam int          FCDMA_NCH          = 4;
    localparam int          FCDMA_AW           = 8;
    // Per-channel registers sit at channel base plus offset, 0x20 bytes per channel.
    localparam logic [7:0]  FCDMA_CH_STRIDE    = 8'h20;
    localparam logic [4:0]  FCDMA_CUR_SRC      = 5'h00;
    localparam logic [4:0]  FCDMA_CUR_DST      = 5'h04;
    localparam logic [4:0]  FCDMA_CUR_CNT      = 5'h08;
    localparam logic [4:0]  FCDMA_RLD_SRC      = 5'h0c;
    localparam logic [4:0]  FCDMA_RLD_DST      = 5'h10;
    localparam logic [4:0]  FCDMA_RLD_CNT      = 5'h14;
    localparam logic [4:0]  FCDMA_MODE         = 5'h18;
    localparam logic [4:0]  FCDMA_CTRL         = 5'h1c;
    // Global registers.
    localparam logic [7:0]  FCDMA_GLB_START    = 8'h80;
    localparam logic [7:0]  FCDMA_GLB_IRQEN    = 8'h84;
    localparam logic [7:0]  FCDMA_GLB_ARB      = 8'h88;
    localparam logic [7:0]  FCDMA_GLB_END      = 8'h8c;
    // Mode register fields.
    localparam int          FCDMA_SRC_INC_BIT  = 0;
    localparam int          FCDMA_DST_INC_BIT  = 1;
    localparam int          FCDMA_SIZE_LSB     = 2;
    // Control register fields.
    localparam int          FCDMA_EN_BIT       = 0;
    localparam int          FCDMA_RELOAD_BIT   = 1;
    localparam int          FCDMA_AUTOCLR_BIT  = 2;
    localparam int          FCDMA_INIT_BIT     = 3;
    localparam int          FCDMA_XMODE_LSB    = 4;
    localparam int          FCDMA_REQSEL_LSB   = 6;
    localparam int          FCDMA_OPLOG_LSB    = 8;
    localparam int          FCDMA_SWTRIG_BIT   = 11;
    localparam int          FCDMA_PEND_BIT     = 16;
    localparam logic [25:0] FCDMA_CNT_MAX      = 26'h3ffffff;
    localparam logic [31:0] FCDMA_ZERO_RST     = 32'h0000_0000;
    localparam logic [2:0]  FCDMA_OPLOG_MAX    = 3'h7;
    typedef enum logic [1:0] {FCDMA_SZ8, FCDMA_SZ16, FCDMA_SZ32, FCDMA_SZ_RSV} fcdma_size_t;
    typedef enum logic [1:0] {FCDMA_SINGLE, FCDMA_CONSEC, FCDMA_NONSTOP, FCDMA_XRSV} fcdma_xmode_t;
    typedef enum logic [1:0] {FCDMA_REQ_SW, FCDMA_REQ_PIN, FCDMA_REQ_PERIPH, FCDMA_REQ_RSV}
        fcdma_reqsel_t;
endpackage : fcdma_pkg

// ---- rtl/fcdma_top.sv ----
// Four-channel DMA controller: registers, arbitration, channel counters and bus master.
// Assumes a bus that accepts one data unit per bus_req/bus_ack handshake from the same clock.
// Function
// - Four channels, channel zero highest priority.
// - Counter drops by unit bytes each move.
// - Zero count stops channel, raises end request.
// - Unit width selectable 8, 16, 32 bits.
// - Operand holds power-of-two units, 1 to 128.
// - Single mode: one operand per request.
// - Consecutive mode: one request runs all operands.
// - Nonstop mode: one request runs to end.
// - Start needs enable, global start, won request.
// - 32-bit addresses, 26-bit byte count.
// - Request source: software, pin, peripheral.
// - Reload registers copy into current registers.
// - Mode register sets address steps, unit size.
// - End interrupt enabled per channel.
// - Arbitration status shows active channels.
// - Transfer-end register terminates any channel.
// - Pending request readable per channel.
// - Setting chooses auto-clear of enable at end.
// - Init command resets channel internal state.
// - Transmit example: channel 1, byte, fixed destination.
// - Receive example: channel 0, byte, fixed source.
// - Operation moves exactly programmed bytes when count is a multiple of unit size.
`timescale 1ns/1ps
module fcdma_top
    import fcdma_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [3:0]  pin_trig,
    input  wire logic [3:0]  periph_req,
    output logic             bus_req,
    output logic             bus_write,
    output logic      [31:0] bus_addr,
    output logic      [1:0]  bus_size,
    input  wire logic        bus_ack,
    input  wire logic [31:0] bus_rdata,
    output logic      [31:0] bus_wdata,
    output logic      [3:0]  end_irq
);
    typedef enum logic [1:0] {FCDMA_IDLE, FCDMA_RD, FCDMA_WR} fcdma_st_t;

    logic [31:0] cur_src_ff [FCDMA_NCH];
    logic [31:0] cur_dst_ff [FCDMA_NCH];
    logic [25:0] cur_cnt_ff [FCDMA_NCH];
    logic [31:0] rld_src_ff [FCDMA_NCH];
    logic [31:0] rld_dst_ff [FCDMA_NCH];
    logic [25:0] rld_cnt_ff [FCDMA_NCH];
    logic [3:0]  mode_ff    [FCDMA_NCH];
    logic [10:0] ctrl_ff    [FCDMA_NCH];
    logic [3:0]  pend_ff;
    logic [3:0]  run_ff;
    logic [3:0]  pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [3:0]  per_s1_ff, per_s2_ff, per_s3_ff;
    logic        start_ff;
    logic [3:0]  irqen_ff;
    logic [3:0]  end_irq_ff;
    fcdma_st_t   st_ff;
    logic [1:0]  ch_ff;
    logic [7:0]  unit_left_ff;
    logic [31:0] data_ff;
    logic [31:0] rdata_ff;
    logic [3:0]  eligible;
    logic [3:0]  edge_req;
    logic [3:0]  sw_trig;
    logic [3:0]  init_cmd;
    logic [3:0]  end_cmd;
    logic [3:0]  done_now;
    logic [1:0]  grant_ch;
    logic        grant_vld;
    logic [25:0] unit_bytes;
    logic        last_unit;
    logic        op_done;

    // Pins and peripheral requests come from other logic; synchronise, then edge-detect.
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_s3_ff <= 4'h0;
            per_s1_ff <= 4'h0;
            per_s2_ff <= 4'h0;
            per_s3_ff <= 4'h0;
        end else begin
            pin_s1_ff <= pin_trig;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            per_s1_ff <= periph_req;
            per_s2_ff <= per_s1_ff;
            per_s3_ff <= per_s2_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < FCDMA_NCH; g = g + 1) begin : g_ch
            logic [7:0] ch_base;
            assign ch_base = FCDMA_CH_STRIDE * 8'(g);
            assign sw_trig[g]  = reg_wr && reg_addr == (ch_base | 8'(FCDMA_CTRL))
                                 && reg_wdata[FCDMA_SWTRIG_BIT];
            assign init_cmd[g] = reg_wr && reg_addr == (ch_base | 8'(FCDMA_CTRL))
                                 && reg_wdata[FCDMA_INIT_BIT];
            assign end_cmd[g]  = reg_wr && reg_addr == FCDMA_GLB_END && reg_wdata[g];
            always_comb begin
                case (fcdma_reqsel_t'(ctrl_ff[g][FCDMA_REQSEL_LSB +: 2]))
                    FCDMA_REQ_SW:     edge_req[g] = sw_trig[g];
                    FCDMA_REQ_PIN:    edge_req[g] = pin_s2_ff[g] & ~pin_s3_ff[g];
                    FCDMA_REQ_PERIPH: edge_req[g] = per_s2_ff[g] & ~per_s3_ff[g];
                    default:          edge_req[g] = 1'b0;
                endcase
            end
            // Enable, global start, a pending request or running transfer, and a nonzero count are all needed.
            assign eligible[g] = ctrl_ff[g][FCDMA_EN_BIT] && start_ff
                                 && (pend_ff[g] || run_ff[g]) && cur_cnt_ff[g] != 26'h0;
            assign done_now[g] = op_done && ch_ff == 2'(g) && last_unit
                                 && cur_cnt_ff[g] == unit_bytes;

            always_ff @(posedge mclk) begin
                if (reset) begin
                    cur_src_ff[g] <= FCDMA_ZERO_RST;
                    cur_dst_ff[g] <= FCDMA_ZERO_RST;
                    cur_cnt_ff[g] <= 26'h0;
                    rld_src_ff[g] <= FCDMA_ZERO_RST;
                    rld_dst_ff[g] <= FCDMA_ZERO_RST;
                    rld_cnt_ff[g] <= 26'h0;
                    mode_ff[g]    <= 4'h0;
                    ctrl_ff[g]    <= 11'h0;
                    pend_ff[g]    <= 1'b0;
                    run_ff[g]     <= 1'b0;
                    end_irq_ff[g] <= 1'b0;
                end else begin
                    end_irq_ff[g] <= done_now[g] && irqen_ff[g];
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_CUR_SRC)))
                        cur_src_ff[g] <= reg_wdata;
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_CUR_DST)))
                        cur_dst_ff[g] <= reg_wdata;
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_CUR_CNT)))
                        cur_cnt_ff[g] <= reg_wdata[25:0] & FCDMA_CNT_MAX;
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_RLD_SRC)))
                        rld_src_ff[g] <= reg_wdata;
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_RLD_DST)))
                        rld_dst_ff[g] <= reg_wdata;
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_RLD_CNT)))
                        rld_cnt_ff[g] <= reg_wdata[25:0];
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_MODE)))
                        mode_ff[g] <= reg_wdata[3:0];
                    if (reg_wr && reg_addr == (ch_base | 8'(FCDMA_CTRL)))
                        ctrl_ff[g] <= {reg_wdata[10:4], 1'b0, reg_wdata[2:0]};
                    // Address and count advance as each unit lands at its destination.
                    if (st_ff == FCDMA_WR && bus_ack && ch_ff == 2'(g)) begin
                        if (mode_ff[g][FCDMA_SRC_INC_BIT])
                            cur_src_ff[g] <= cur_src_ff[g] + 32'(unit_bytes);
                        if (mode_ff[g][FCDMA_DST_INC_BIT])
                            cur_dst_ff[g] <= cur_dst_ff[g] + 32'(unit_bytes);
                        cur_cnt_ff[g] <= cur_cnt_ff[g] - unit_bytes;
                    end
                    // A new request sets pending; it wins over the grant and end clears.
                    if (op_done && ch_ff == 2'(g)
                        && ctrl_ff[g][FCDMA_XMODE_LSB +: 2] == 2'(FCDMA_SINGLE))
                        pend_ff[g] <= 1'b0;
                    if (grant_vld && st_ff == FCDMA_IDLE && grant_ch == 2'(g)
                        && ctrl_ff[g][FCDMA_XMODE_LSB +: 2] != 2'(FCDMA_SINGLE)) begin
                        pend_ff[g] <= 1'b0;
                        run_ff[g]  <= 1'b1;
                    end
                    if (done_now[g]) begin
                        run_ff[g]  <= 1'b0;
                        pend_ff[g] <= 1'b0;
                        if (ctrl_ff[g][FCDMA_AUTOCLR_BIT])
                            ctrl_ff[g][FCDMA_EN_BIT] <= 1'b0;
                        // Reload lands with the final count, before any later request.
                        if (ctrl_ff[g][FCDMA_RELOAD_BIT]) begin
                            cur_src_ff[g] <= rld_src_ff[g];
                            cur_dst_ff[g] <= rld_dst_ff[g];
                            cur_cnt_ff[g] <= rld_cnt_ff[g];
                        end
                    end
                    if (edge_req[g])
                        pend_ff[g] <= 1'b1;
                    if (end_cmd[g] || init_cmd[g]) begin
                        run_ff[g]  <= 1'b0;
                        pend_ff[g] <= 1'b0;
                        ctrl_ff[g][FCDMA_EN_BIT] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Fixed priority: lowest channel index wins among eligible ones.
    always_comb begin
        grant_vld = 1'b0;
        grant_ch  = 2'h0;
        for (int i = FCDMA_NCH - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                grant_vld = 1'b1;
                grant_ch  = 2'(i);
            end
        end
    end

    always_comb begin
        case (fcdma_size_t'(mode_ff[ch_ff][FCDMA_SIZE_LSB +: 2]))
            FCDMA_SZ8:  unit_bytes = 26'h1;
            FCDMA_SZ16: unit_bytes = 26'h2;
            FCDMA_SZ32: unit_bytes = 26'h4;
            default:    unit_bytes = 26'h1;
        endcase
    end

    assign last_unit = unit_left_ff == 8'h1 || cur_cnt_ff[ch_ff] == unit_bytes;
    assign op_done   = st_ff == FCDMA_WR && bus_ack && last_unit;

    // Transfer engine: read unit, write unit; arbitration only between operands.
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff        <= FCDMA_IDLE;
            ch_ff        <= 2'h0;
            unit_left_ff <= 8'h0;
            data_ff      <= FCDMA_ZERO_RST;
        end else begin
            case (st_ff)
                FCDMA_IDLE: begin
                    if (grant_vld) begin
                        st_ff        <= FCDMA_RD;
                        ch_ff        <= grant_ch;
                        unit_left_ff <= 8'h1 << ctrl_ff[grant_ch][FCDMA_OPLOG_LSB +: 3];
                    end
                end
                FCDMA_RD: begin
                    if (end_cmd[ch_ff] || init_cmd[ch_ff]) begin
                        st_ff <= FCDMA_IDLE;
                    end else if (bus_ack) begin
                        st_ff   <= FCDMA_WR;
                        data_ff <= bus_rdata;
                    end
                end
                FCDMA_WR: begin
                    if (bus_ack) begin
                        unit_left_ff <= unit_left_ff - 8'h1;
                        st_ff        <= last_unit ? FCDMA_IDLE : FCDMA_RD;
                    end
                end
                default: st_ff <= FCDMA_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            start_ff <= 1'b0;
            irqen_ff <= 4'h0;
        end else if (reg_wr && reg_addr == FCDMA_GLB_START) begin
            start_ff <= reg_wdata[0];
        end else if (reg_wr && reg_addr == FCDMA_GLB_IRQEN) begin
            irqen_ff <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_ff <= FCDMA_ZERO_RST;
        end else if (reg_rd) begin
            rdata_ff <= FCDMA_ZERO_RST;
            if (reg_addr < FCDMA_GLB_START) begin
                case (reg_addr[4:0])
                    FCDMA_CUR_SRC: rdata_ff <= cur_src_ff[reg_addr[6:5]];
                    FCDMA_CUR_DST: rdata_ff <= cur_dst_ff[reg_addr[6:5]];
                    FCDMA_CUR_CNT: rdata_ff <= {6'h0, cur_cnt_ff[reg_addr[6:5]]};
                    FCDMA_RLD_SRC: rdata_ff <= rld_src_ff[reg_addr[6:5]];
                    FCDMA_RLD_DST: rdata_ff <= rld_dst_ff[reg_addr[6:5]];
                    FCDMA_RLD_CNT: rdata_ff <= {6'h0, rld_cnt_ff[reg_addr[6:5]]};
                    FCDMA_MODE:    rdata_ff <= {28'h0, mode_ff[reg_addr[6:5]]};
                    FCDMA_CTRL:    rdata_ff <= {15'h0, pend_ff[reg_addr[6:5]], 5'h0,
                                               ctrl_ff[reg_addr[6:5]]};
                    default:       rdata_ff <= FCDMA_ZERO_RST;
                endcase
            end else begin
                case (reg_addr)
                    FCDMA_GLB_START: rdata_ff <= {31'h0, start_ff};
                    FCDMA_GLB_IRQEN: rdata_ff <= {28'h0, irqen_ff};
                    FCDMA_GLB_ARB:   rdata_ff <= {28'h0, run_ff | ((st_ff != FCDMA_IDLE)
                                                  ? (4'h1 << ch_ff) : 4'h0)};
                    default:         rdata_ff <= FCDMA_ZERO_RST;
                endcase
            end
        end
    end

    // Bus outputs are registered from the next state so each comes from a flip-flop.
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_req   <= 1'b0;
            bus_write <= 1'b0;
            bus_addr  <= FCDMA_ZERO_RST;
            bus_size  <= 2'h0;
            bus_wdata <= FCDMA_ZERO_RST;
        end else begin
            bus_req <= 1'b0;
            if (st_ff == FCDMA_IDLE && grant_vld) begin
                bus_req   <= 1'b1;
                bus_write <= 1'b0;
                bus_addr  <= cur_src_ff[grant_ch];
                bus_size  <= mode_ff[grant_ch][FCDMA_SIZE_LSB +: 2];
            end else if (st_ff == FCDMA_RD && bus_ack
                         && !(end_cmd[ch_ff] || init_cmd[ch_ff])) begin
                bus_req   <= 1'b1;
                bus_write <= 1'b1;
                bus_addr  <= cur_dst_ff[ch_ff];
                bus_wdata <= bus_rdata;
            end else if (st_ff == FCDMA_WR && bus_ack && !last_unit) begin
                bus_req   <= 1'b1;
                bus_write <= 1'b0;
                bus_addr  <= mode_ff[ch_ff][FCDMA_SRC_INC_BIT]
                             ? cur_src_ff[ch_ff] + 32'(unit_bytes) : cur_src_ff[ch_ff];
            // An aborted read drops its request so no stale answer is taken later.
            end else if (st_ff != FCDMA_IDLE && !bus_ack
                         && !(st_ff == FCDMA_RD && (end_cmd[ch_ff] || init_cmd[ch_ff]))) begin
                bus_req <= bus_req;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign end_irq   = end_irq_ff;

    a_end_irq_cause: assert property (@(posedge mclk) disable iff (reset)
        $rose(end_irq[1]) |-> cur_cnt_ff[1] == 26'h0 || ctrl_ff[1][FCDMA_RELOAD_BIT])
        else $error("end interrupt without exhausted count");
    a_single_grant: assert property (@(posedge mclk) disable iff (reset)
        (st_ff == FCDMA_IDLE && eligible[0]) |-> grant_ch == 2'h0)
        else $error("channel zero lost arbitration");
    a_start_gate: assert property (@(posedge mclk) disable iff (reset)
        (st_ff == FCDMA_IDLE ##1 st_ff == FCDMA_RD) |-> $past(start_ff))
        else $error("transfer began without global start");
    a_cnt_step: assert property (@(posedge mclk) disable iff (reset)
        (st_ff == FCDMA_WR && bus_ack && !done_now[ch_ff] && !end_cmd[ch_ff])
        |=> cur_cnt_ff[$past(ch_ff)] == $past(cur_cnt_ff[ch_ff]) - $past(unit_bytes))
        else $error("byte count did not drop by unit size");
    a_irq_mask: assert property (@(posedge mclk) disable iff (reset)
        end_irq[2] |-> $past(irqen_ff[2]))
        else $error("masked channel raised end interrupt");
    a_end_cmd: assert property (@(posedge mclk) disable iff (reset)
        end_cmd[3] |=> !run_ff[3] && !pend_ff[3])
        else $error("terminate did not stop channel");
    a_pend_set: assert property (@(posedge mclk) disable iff (reset)
        (edge_req[1] && !end_cmd[1] && !init_cmd[1] && !done_now[1]) |=> pend_ff[1])
        else $error("request not recorded as pending");
    a_autoclr_en: assert property (@(posedge mclk) disable iff (reset)
        (done_now[0] && ctrl_ff[0][FCDMA_AUTOCLR_BIT]) |=> !ctrl_ff[0][FCDMA_EN_BIT])
        else $error("enable not cleared at end");
    a_reload_cnt: assert property (@(posedge mclk) disable iff (reset)
        (done_now[2] && ctrl_ff[2][FCDMA_RELOAD_BIT])
        |=> cur_cnt_ff[2] == $past(rld_cnt_ff[2]))
        else $error("reload count not copied at end");
    a_src_fixed: assert property (@(posedge mclk) disable iff (reset)
        (st_ff == FCDMA_WR && bus_ack && ch_ff == 2'h0 && !mode_ff[0][FCDMA_SRC_INC_BIT]
         && !done_now[0] && !reg_wr) |=> cur_src_ff[0] == $past(cur_src_ff[0]))
        else $error("fixed source address moved");
    a_dst_fixed: assert property (@(posedge mclk) disable iff (reset)
        (st_ff == FCDMA_WR && bus_ack && ch_ff == 2'h1 && !mode_ff[1][FCDMA_DST_INC_BIT]
         && !done_now[1] && !reg_wr) |=> cur_dst_ff[1] == $past(cur_dst_ff[1]))
        else $error("fixed destination address moved");
endmodule : fcdma_top

// ---- bench/fcdma_mem_model.sv ----
// Behavioural memory on the far side of the controller's bus master link.
// Assumes the one-clock bus_req/bus_ack handshake; answers with a varying delay.
`timescale 1ns/1ps
module fcdma_mem_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        bus_req,
    input  wire logic [31:0] bus_addr,
    output logic             bus_ack,
    output logic      [31:0] bus_rdata
);
    logic [2:0] pace_ff;
    logic [1:0] wait_ff;
    logic       go;
    assign go = bus_req && !bus_ack && (wait_ff >= pace_ff[2:1]);
    // The wait grows every second transfer and wraps after eight, so prompt and slow answers both occur.
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_ack <= 1'b0;
            wait_ff <= 2'h0;
            pace_ff <= 3'h0;
        end else if (bus_ack) begin
            bus_ack <= 1'b0;
            wait_ff <= 2'h0;
            pace_ff <= pace_ff + 3'h1;
        end else if (go) begin
            bus_ack <= 1'b1;
        end else if (bus_req) begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
    // Outside an answer the data toggle, so stale read data can never pass.
    always_ff @(posedge mclk) begin
        if (go) begin
            bus_rdata <= bus_addr ^ 32'ha5c3_0f96;
        end else begin
            bus_rdata <= ~bus_rdata;
        end
    end
endmodule : fcdma_mem_model

// ---- bench/four_channel_dma_controller_tb.sv ----
// Self-checking bench for the four-channel DMA controller with a memory model.
// Assumes the plain strobe register port and a 50 MHz clock.
`timescale 1ns/1ps
module four_channel_dma_controller_tb;
    import fcdma_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, bus_addr, bus_rdata, bus_wdata, s0, s1, s2;
    logic [3:0]  pin_trig = 4'h0, periph_req = 4'h0, end_irq;
    logic        bus_req, bus_write, bus_ack;
    logic [1:0]  bus_size;
    logic [15:0] seed = 16'h1362;
    logic [66:0] wq[$];
    logic [63:0] rq[$];
    int          fails = 0, num_checks = 0, irqs[4] = '{0, 0, 0, 0};
    always #10 mclk = ~mclk;
    fcdma_top dut_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pin_trig, .periph_req, .bus_req, .bus_write, .bus_addr, .bus_size, .bus_ack,
        .bus_rdata, .bus_wdata, .end_irq);
    fcdma_mem_model mem_u (.mclk, .reset, .bus_req, .bus_addr, .bus_ack, .bus_rdata);
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function logic [7:0] ra(input int ch, input logic [4:0] off);
        return FCDMA_CH_STRIDE * 8'(ch) + {3'h0, off};
    endfunction : ra
    function logic [31:0] cfg(input logic [1:0] xm, rs, input logic [2:0] lg, input int ex);
        return 32'(ex) | 32'h1 | ({30'h0, xm} << FCDMA_XMODE_LSB)
            | ({30'h0, rs} << FCDMA_REQSEL_LSB) | ({29'h0, lg} << FCDMA_OPLOG_LSB);
    endfunction : cfg
    task chk(input string what, input logic [66:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, m);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back({e & m, m});
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd
    task setup(input int ch, input logic [31:0] src, dst, cnt, input logic [1:0] sz,
               input logic si, di, input logic [31:0] ctrl);
        wr(ra(ch, FCDMA_CUR_SRC), src);
        wr(ra(ch, FCDMA_CUR_DST), dst);
        wr(ra(ch, FCDMA_CUR_CNT), cnt);
        wr(ra(ch, FCDMA_MODE), {28'h0, sz, di, si});
        wr(ra(ch, FCDMA_CTRL), ctrl);
    endtask : setup
    task ew(input logic [1:0] sz, input logic [31:0] a, d, input logic full);
        wq.push_back({full, sz, a, full ? d : 32'h0});
    endtask : ew
    task pulse(input logic [3:0] p, pn);
        @(posedge mclk);
        periph_req <= p;
        pin_trig <= pn;
        repeat (4) @(posedge mclk);
        periph_req <= 4'h0;
        pin_trig <= 4'h0;
        repeat (4) @(posedge mclk);
    endtask : pulse
    task drain;
        int n;
        n = 0;
        while (wq.size() != 0 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        if (wq.size() != 0) chk("pending transfers", 67'h0, 67'(wq.size()));
        wq.delete();
        repeat (10) @(posedge mclk);
    endtask : drain
    always @(posedge mclk) begin
        if (rd_seen) begin
            chk("reg_rdata", 67'(rq[0][63:32]), 67'(reg_rdata & rq[0][31:0]));
            void'(rq.pop_front());
        end
        rd_seen <= reg_rd;
        if (bus_req && bus_ack && bus_write) begin
            if (wq.size() == 0) chk("unexpected write", 67'h0, {1'b1, bus_size, bus_addr, bus_wdata});
            else begin
                chk("bus write", wq[0], {wq[0][66], bus_size, bus_addr, wq[0][66] ? bus_wdata : 32'h0});
                void'(wq.pop_front());
            end
        end
        for (int i = 0; i < 4; i++) if (end_irq[i]) irqs[i]++;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        fails++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd(ra(0, FCDMA_CUR_CNT), 32'h0, '1);
        rd(8'h9c, 32'h0, '1);
        s0 = {16'h2000, seed};
        seed = lfsr(seed);
        s1 = {16'h2100, seed};
        seed = lfsr(seed);
        s2 = {16'h3000, seed & 16'hfffc};
        setup(0, 32'h1000, s0, 32'h3, FCDMA_SZ8, 1'b0, 1'b1, cfg(FCDMA_SINGLE, FCDMA_REQ_PERIPH, 3'h0, 4));
        setup(1, s1, 32'h1004, 32'h3, FCDMA_SZ8, 1'b1, 1'b0, cfg(FCDMA_SINGLE, FCDMA_REQ_PERIPH, 3'h0, 0));
        wr(FCDMA_GLB_IRQEN, 32'h7);
        wr(FCDMA_GLB_START, 32'h1);
        for (int k = 0; k < 3; k++) begin
            ew(FCDMA_SZ8, s0 + 32'(k), 32'h0, 1'b0);
            ew(FCDMA_SZ8, 32'h1004, 32'h0, 1'b0);
            pulse(4'h3, 4'h0);
            drain;
        end
        rd(ra(0, FCDMA_CUR_CNT), 32'h0, '1);
        rd(FCDMA_GLB_ARB, 32'h0, 32'hf);
        rd(ra(0, FCDMA_CTRL), 32'h0, 32'h1);
        wr(ra(2, FCDMA_RLD_SRC), 32'h4000);
        wr(ra(2, FCDMA_RLD_CNT), 32'h8);
        for (int k = 0; k < 4; k++) ew(FCDMA_SZ32, 32'h5000 + 32'(4 * k), (s2 + 32'(4 * k)) ^ 32'ha5c3_0f96, 1'b1);
        setup(2, s2, 32'h5000, 32'h10, FCDMA_SZ32, 1'b1, 1'b1, cfg(FCDMA_CONSEC, FCDMA_REQ_SW, 3'h1, 32'h802));
        drain;
        rd(ra(2, FCDMA_CUR_CNT), 32'h8, '1);
        rd(ra(2, FCDMA_CUR_SRC), 32'h4000, '1);
        for (int k = 0; k < 3; k++) ew(FCDMA_SZ16, 32'h6000, 32'h0, 1'b0);
        setup(3, s2, 32'h6000, 32'h6, FCDMA_SZ16, 1'b1, 1'b0, cfg(FCDMA_NONSTOP, FCDMA_REQ_PIN, 3'h0, 0));
        pulse(4'h0, 4'h8);
        drain;
        wr(FCDMA_GLB_START, 32'h0);
        setup(3, s2, 32'h6000, 32'h4, FCDMA_SZ8, 1'b1, 1'b0, cfg(FCDMA_SINGLE, FCDMA_REQ_SW, 3'h0, 32'h800));
        wr(ra(3, FCDMA_CTRL), cfg(FCDMA_SINGLE, FCDMA_REQ_SW, 3'h0, 32'h800));
        repeat (20) @(posedge mclk);
        rd(ra(3, FCDMA_CTRL), 32'h10000, 32'h10000);
        wr(FCDMA_GLB_END, 32'h8);
        rd(ra(3, FCDMA_CTRL), 32'h0, 32'h10001);
        wr(FCDMA_GLB_START, 32'h1);
        repeat (20) @(posedge mclk);
        for (int i = 0; i < 4; i++) chk("end_irq count", (i == 3) ? 67'h0 : 67'h1, 67'(irqs[i]));
        finish_test;
    end
endmodule : four_channel_dma_controller_tb
